// ===== rtl/completion_credit_limiter.sv
// Behaviour
// - issue a non-posted request only when reserved completion space can take all replies.
// - kept end-to-end digests count as completion data payload.
// - read size limit from device control bits 14:12; codes 110b, 111b reserved.
// - without that field assume 128 bytes, eight data credits.
// - completion boundary from link control bit 3: 64 or 128 bytes.
// - without that bit assume a 64 byte completion boundary.
// - completers split replies only on aligned boundaries, except first and last.
// - reserve one header credit per boundary block the reply could span.
// - headers per full read are read limit over boundary, rounded up.
// - reads fitting data pool are data capacity over read credits, rounded down.
// - reads fitting header pool are header capacity over headers per read, down.
// - ceiling on outstanding requests is the smaller of both pool counts.
// - outstanding counter resets to zero and stays between zero and ceiling.
// - counter moves by one when a non-posted request is sent.
// - counter moves back by one once all completions of a request arrived.
// - every request costs a full maximum-size block, whatever its size.
// - the streaming method must take completions and posted writes at line rate.
// - for streaming the receive ready must stay asserted continuously.
//
// Local design decisions: the Avalon-MM slave port and the register offsets.
`timescale 1ns/1ps
module completion_credit_limiter
	import credit_limiter_pkg::*;
(
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic [2:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic [15:0] cfg_dcommand,
	input wire logic [15:0] cfg_lcommand,
	input wire logic np_req_valid,
	input wire logic [TAG_W-1:0] np_req_tag,
	input wire logic [BYTE_W-1:0] np_req_bytes,
	output logic np_req_done,
	output logic tx_np_valid,
	output logic [TAG_W-1:0] tx_np_tag,
	input wire logic tx_np_ready,
	input wire logic cpl_valid,
	input wire logic [TAG_W-1:0] cpl_tag,
	input wire logic [BYTE_W-1:0] cpl_len,
	output logic cpl_ready,
	output logic at_ceiling
);
	tracker_if trk ();

	gate_state_t state_r;
	gate_state_t state_nxt;
	logic [CTRL_W-1:0] ctrl_r;
	logic [CNT_W-1:0] cap_r;
	logic [CNT_W-1:0] outstanding_nonposted_counter_r;
	logic [CNT_W-1:0] count_nxt;
	logic [CNT_W-1:0] nonposted_ceiling_r;
	logic [TAG_W-1:0] tag_r;
	logic [BYTE_W-1:0] bytes_r;
	logic [31:0] issued_r;
	logic [31:0] retired_r;
	logic [31:0] orphan_r;
	logic [31:0] stall_r;
	logic [31:0] readdata_r;
	logic waitrequest_r;
	logic done_r;
	logic tx_valid_r;
	logic cpl_ready_r;
	logic full_r;

	// Configuration inputs, or the defaults when software says not to use them
	wire use_cfg = ctrl_r[CTRL_USE_CFG];
	wire [2:0] mrrs_field = cfg_dcommand[MRRS_MSB:MRRS_LSB];
	wire mrrs_bad = mrrs_field > MRRS_MAX_CODE;
	// A reserved code falls back to the smallest read limit
	wire [2:0] mrrs_code = (use_cfg && !mrrs_bad) ? mrrs_field : MRRS_DEFAULT;
	wire rcb_sel = use_cfg ? cfg_lcommand[RCB_BIT] : RCB_DEFAULT;
	wire [CNT_W-1:0] ceiling_calc;

	credit_ceiling_calc u_calc (
		.payload_code(ctrl_r[CTRL_PAY_LSB +: 2]),
		.perf_high(ctrl_r[CTRL_PERF]),
		.mrrs_code(mrrs_code),
		.rcb_sel(rcb_sel),
		.digest_kept(ctrl_r[CTRL_DIGEST]),
		.ceiling(ceiling_calc)
	);

	tag_tracker u_trk (
		.clk_sys(clk_sys),
		.nrst(nrst),
		.trk(trk.tracker)
	);

	// Software cap may only lower the computed ceiling
	wire cap_on = (cap_r != '0) && (cap_r < nonposted_ceiling_r);
	wire [CNT_W-1:0] eff_ceiling = cap_on ? cap_r : nonposted_ceiling_r;
	wire below_ceiling = outstanding_nonposted_counter_r < eff_ceiling;
	wire gate_open = ctrl_r[CTRL_EN] & below_ceiling & ~trk.query_busy;
	wire take = (state_r == GATE_IDLE) & np_req_valid & gate_open;
	wire sent = (state_r == GATE_HOLD) & tx_np_ready;
	wire retire = trk.done;
	wire stalled = (state_r == GATE_IDLE) & np_req_valid & ~gate_open;

	assign trk.alloc_valid = sent;
	assign trk.alloc_tag = tag_r;
	assign trk.alloc_bytes = bytes_r;
	assign trk.cpl_valid = cpl_valid & cpl_ready_r;
	assign trk.cpl_tag = cpl_tag;
	assign trk.cpl_len = cpl_len;
	assign trk.query_tag = np_req_tag;

	// Gate sequence: take a held request, offer it to the core, acknowledge the user
	always_comb
	begin
		state_nxt = state_r;
		case (state_r)
			GATE_IDLE:
			begin
				if (take)
					state_nxt = GATE_HOLD;
			end
			GATE_HOLD:
			begin
				if (tx_np_ready)
					state_nxt = GATE_ACK;
			end
			GATE_ACK:
				state_nxt = GATE_IDLE;
			default:
				state_nxt = GATE_IDLE;
		endcase
	end

	// Up on send, down on full retirement; never below zero
	always_comb
	begin
		count_nxt = outstanding_nonposted_counter_r;
		if (sent && !retire)
			count_nxt = CNT_W'(outstanding_nonposted_counter_r + 1'b1);
		else if (retire && !sent && outstanding_nonposted_counter_r != '0)
			count_nxt = CNT_W'(outstanding_nonposted_counter_r - 1'b1);
	end

	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
		begin
			state_r <= GATE_IDLE;
			outstanding_nonposted_counter_r <= '0;
			nonposted_ceiling_r <= '0;
			tag_r <= '0;
			bytes_r <= '0;
		end
		else
		begin
			state_r <= state_nxt;
			outstanding_nonposted_counter_r <= count_nxt;
			nonposted_ceiling_r <= ceiling_calc;
			if (take)
			begin
				tag_r <= np_req_tag;
				bytes_r <= np_req_bytes;
			end
		end
	end

	// Handshake outputs toward the user and the core
	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
		begin
			tx_valid_r <= 1'b0;
			done_r <= 1'b0;
		end
		else
		begin
			tx_valid_r <= (state_nxt == GATE_HOLD);
			done_r <= sent;
		end
	end

	// Receive side and ceiling flag
	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
		begin
			cpl_ready_r <= 1'b0;
			full_r <= 1'b0;
		end
		else
		begin
			// Completions are always taken, so the reserved space never backs up
			cpl_ready_r <= 1'b1;
			full_r <= count_nxt >= eff_ceiling;
		end
	end

	// Register index match, shared by the read select and every write strobe
	function automatic logic at_reg(input logic [2:0] adr, input logic [2:0] idx);
		return adr == idx;
	endfunction

	// Register slave: every access answers on the second edge
	wire acc = (avs_read | avs_write) & waitrequest_r;
	wire wr_fire = avs_write & ~waitrequest_r;
	wire wr_ctrl = wr_fire & at_reg(avs_address, REG_CTRL);
	wire wr_cap = wr_fire & at_reg(avs_address, REG_CAP);
	// Any write to a statistics word clears it
	wire clr_issued = wr_fire & at_reg(avs_address, REG_ISSUED);
	wire clr_retired = wr_fire & at_reg(avs_address, REG_RETIRED);
	wire clr_orphan = wr_fire & at_reg(avs_address, REG_ORPHAN);
	wire clr_stall = wr_fire & at_reg(avs_address, REG_STALL);

	wire [31:0] status_word = {13'h0000, mrrs_bad & use_cfg, full_r,
		state_r != GATE_IDLE, 1'b0, nonposted_ceiling_r, 1'b0,
		outstanding_nonposted_counter_r};
	wire [31:0] rd_mux =
		at_reg(avs_address, REG_CTRL) ? {26'h0, ctrl_r} :
		at_reg(avs_address, REG_CAP) ? {25'h0, cap_r} :
		at_reg(avs_address, REG_STATUS) ? status_word :
		at_reg(avs_address, REG_ISSUED) ? issued_r :
		at_reg(avs_address, REG_RETIRED) ? retired_r :
		at_reg(avs_address, REG_ORPHAN) ? orphan_r :
		at_reg(avs_address, REG_STALL) ? stall_r : 32'h0000_0000;

	// Handshake and read capture
	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
		begin
			waitrequest_r <= 1'b1;
			readdata_r <= '0;
		end
		else
		begin
			waitrequest_r <= ~acc;
			if (acc && avs_read)
				readdata_r <= rd_mux;
		end
	end

	// Software control words
	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
		begin
			ctrl_r <= CTRL_RST;
			cap_r <= '0;
		end
		else
		begin
			if (wr_ctrl)
				ctrl_r <= avs_writedata[CTRL_W-1:0];
			if (wr_cap)
				cap_r <= avs_writedata[CNT_W-1:0];
		end
	end

	// Statistics; a software clear wins over an event in the same cycle
	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
			issued_r <= '0;
		else if (clr_issued)
			issued_r <= '0;
		else if (sent)
			issued_r <= issued_r + 32'h0000_0001;
	end

	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
			retired_r <= '0;
		else if (clr_retired)
			retired_r <= '0;
		else if (retire)
			retired_r <= retired_r + 32'h0000_0001;
	end

	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
			orphan_r <= '0;
		else if (clr_orphan)
			orphan_r <= '0;
		else if (trk.orphan)
			orphan_r <= orphan_r + 32'h0000_0001;
	end

	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
			stall_r <= '0;
		else if (clr_stall)
			stall_r <= '0;
		else if (stalled)
			stall_r <= stall_r + 32'h0000_0001;
	end

	assign avs_readdata = readdata_r;
	assign avs_waitrequest = waitrequest_r;
	assign np_req_done = done_r;
	assign tx_np_valid = tx_valid_r;
	assign tx_np_tag = tag_r;
	assign cpl_ready = cpl_ready_r;
	assign at_ceiling = full_r;
endmodule

// ===== rtl/credit_ceiling_calc.sv
`timescale 1ns/1ps
module credit_ceiling_calc
	import credit_limiter_pkg::*;
(
	input wire logic [1:0] payload_code,
	input wire logic perf_high,
	input wire logic [2:0] mrrs_code,
	input wire logic rcb_sel,
	input wire logic digest_kept,
	output logic [CNT_W-1:0] ceiling
);
	function automatic logic [CAP_W-1:0] data_capacity(input logic [1:0] code, input logic hi);
		logic [CAP_W-1:0] v;
		v = 10'h000;
		if (code == PAYLOAD_128 || code == PAYLOAD_256)
			v = hi ? DATA_CAP_205 : DATA_CAP_77;
		else if (code == PAYLOAD_512)
			v = hi ? DATA_CAP_461 : DATA_CAP_205;
		else
			v = hi ? DATA_CAP_973 : DATA_CAP_461;
		return v;
	endfunction

	wire [CR_W-1:0] mrrs_cr = CR_W'(MRRS_BASE_CREDITS << mrrs_code);
	wire [CR_W-1:0] rcb_cr = rcb_sel ? RCB128_CREDITS : RCB64_CREDITS;
	// Headers per full-size read, rounded up
	wire [CR_W-1:0] hdr_per = CR_W'((mrrs_cr + rcb_cr - 10'h001) / rcb_cr);
	// Kept digests add one word per completion to the data
	wire [CR_W-1:0] digest_cr = digest_kept ?
		CR_W'((hdr_per + DIGESTS_PER_CREDIT - 10'h001) / DIGESTS_PER_CREDIT) : 10'h000;
	wire [CR_W-1:0] data_per = CR_W'(mrrs_cr + digest_cr);
	wire [CAP_W-1:0] fit_data = data_capacity(payload_code, perf_high) / data_per;
	wire [CAP_W-1:0] fit_hdr = HDR_CAP / hdr_per;
	wire [CAP_W-1:0] fit_min = (fit_data < fit_hdr) ? fit_data : fit_hdr;
	assign ceiling = CNT_W'(fit_min);
endmodule

// ===== rtl/credit_limiter_pkg.sv
package credit_limiter_pkg;

	// Widths of the admission logic
	localparam int TAG_W = 5;
	localparam int TAG_NUM = 32;
	localparam int BYTE_W = 13;
	localparam int CNT_W = 7;
	localparam int CAP_W = 10;
	localparam int CR_W = 10;

	// Completion space reserved by the core, in credits
	localparam logic [CAP_W-1:0] HDR_CAP = 10'h024;
	localparam logic [CAP_W-1:0] DATA_CAP_77 = 10'h04D;
	localparam logic [CAP_W-1:0] DATA_CAP_205 = 10'h0CD;
	localparam logic [CAP_W-1:0] DATA_CAP_461 = 10'h1CD;
	localparam logic [CAP_W-1:0] DATA_CAP_973 = 10'h3CD;

	// Payload size setting codes: 128, 256, 512, 1024 bytes
	localparam logic [1:0] PAYLOAD_128 = 2'h0;
	localparam logic [1:0] PAYLOAD_256 = 2'h1;
	localparam logic [1:0] PAYLOAD_512 = 2'h2;

	// Configuration space fields
	localparam int MRRS_LSB = 12;
	localparam int MRRS_MSB = 14;
	localparam logic [2:0] MRRS_MAX_CODE = 3'h5;
	localparam logic [2:0] MRRS_DEFAULT = 3'h0;
	localparam int RCB_BIT = 3;
	localparam logic RCB_DEFAULT = 1'h0;
	localparam logic [CR_W-1:0] MRRS_BASE_CREDITS = 10'h008;
	localparam logic [CR_W-1:0] RCB64_CREDITS = 10'h004;
	localparam logic [CR_W-1:0] RCB128_CREDITS = 10'h008;
	localparam logic [CR_W-1:0] DIGESTS_PER_CREDIT = 10'h004;

	// Register word indices
	localparam logic [2:0] REG_CTRL = 3'h0;
	localparam logic [2:0] REG_CAP = 3'h1;
	localparam logic [2:0] REG_STATUS = 3'h2;
	localparam logic [2:0] REG_ISSUED = 3'h3;
	localparam logic [2:0] REG_RETIRED = 3'h4;
	localparam logic [2:0] REG_ORPHAN = 3'h5;
	localparam logic [2:0] REG_STALL = 3'h6;

	// Control fields
	localparam int CTRL_EN = 0;
	localparam int CTRL_USE_CFG = 1;
	localparam int CTRL_DIGEST = 2;
	localparam int CTRL_PERF = 3;
	localparam int CTRL_PAY_LSB = 4;
	localparam int CTRL_W = 6;
	localparam logic [CTRL_W-1:0] CTRL_RST = 6'h01;

	// Status fields
	localparam int ST_CEIL_LSB = 8;
	localparam int ST_HOLD = 16;
	localparam int ST_FULL = 17;
	localparam int ST_MRRS_BAD = 18;

	typedef enum logic [1:0] {GATE_IDLE, GATE_HOLD, GATE_ACK} gate_state_t;

endpackage

// ===== rtl/tag_tracker.sv
`timescale 1ns/1ps
module tag_tracker
	import credit_limiter_pkg::*;
(
	input wire logic clk_sys,
	input wire logic nrst,
	tracker_if.tracker trk
);
	logic [BYTE_W-1:0] remain_r [TAG_NUM];
	logic [TAG_NUM-1:0] busy_r;
	logic done_r;
	logic orphan_r;

	wire [BYTE_W-1:0] cur_remain = remain_r[trk.cpl_tag];
	wire cpl_hit = trk.cpl_valid & busy_r[trk.cpl_tag];
	// Request retires when this completion carries its last bytes
	wire cpl_last = cpl_hit & (cur_remain <= trk.cpl_len);

	assign trk.query_busy = busy_r[trk.query_tag];
	assign trk.done = done_r;
	assign trk.orphan = orphan_r;

	genvar i;
	generate
		for (i = 0; i < TAG_NUM; i++)
		begin : g_tag
			always_ff @(posedge clk_sys or negedge nrst)
			begin
				if (!nrst)
					busy_r[i] <= 1'b0;
				else if (trk.alloc_valid && trk.alloc_tag == TAG_W'(i))
					busy_r[i] <= 1'b1;
				else if (cpl_last && trk.cpl_tag == TAG_W'(i))
					busy_r[i] <= 1'b0;
			end
		end
	endgenerate

	always_ff @(posedge clk_sys)
	begin
		if (trk.alloc_valid)
			remain_r[trk.alloc_tag] <= trk.alloc_bytes;
		if (cpl_hit && !cpl_last)
			remain_r[trk.cpl_tag] <= cur_remain - trk.cpl_len;
	end

	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
		begin
			done_r <= 1'b0;
			orphan_r <= 1'b0;
		end
		else
		begin
			done_r <= cpl_last;
			orphan_r <= trk.cpl_valid & ~busy_r[trk.cpl_tag];
		end
	end
endmodule

// ===== rtl/tracker_if.sv
`timescale 1ns/1ps
interface tracker_if;
	import credit_limiter_pkg::*;
	logic alloc_valid;
	logic [TAG_W-1:0] alloc_tag;
	logic [BYTE_W-1:0] alloc_bytes;
	logic cpl_valid;
	logic [TAG_W-1:0] cpl_tag;
	logic [BYTE_W-1:0] cpl_len;
	logic [TAG_W-1:0] query_tag;
	logic query_busy;
	logic done;
	logic orphan;
	modport tracker (input alloc_valid, alloc_tag, alloc_bytes, cpl_valid, cpl_tag, cpl_len,
		query_tag, output query_busy, done, orphan);
	modport owner (output alloc_valid, alloc_tag, alloc_bytes, cpl_valid, cpl_tag, cpl_len,
		query_tag, input query_busy, done, orphan);
endinterface

// ===== test/core_model.sv
`timescale 1ns/1ps
module core_model
	import credit_limiter_pkg::*;
(
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic slow,
	input wire logic hold,
	input wire logic stray,
	input wire logic tx_np_valid,
	input wire logic [TAG_W-1:0] tx_np_tag,
	output logic tx_np_ready,
	output logic cpl_valid,
	output logic [TAG_W-1:0] cpl_tag,
	output logic [BYTE_W-1:0] cpl_len
);
	logic [TAG_W-1:0] pend_q [$];
	logic [1:0] pace_r;
	logic half_r;
	always @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
		begin
			pend_q.delete();
			pace_r <= 2'h0;
			half_r <= 1'b0;
			tx_np_ready <= 1'b0;
			cpl_valid <= 1'b0;
			cpl_tag <= 5'h00;
			cpl_len <= 13'h0000;
		end
		else
		begin
			pace_r <= pace_r + 2'h1;
			tx_np_ready <= !slow || pace_r == 2'h3;
			if (tx_np_valid && tx_np_ready)
				pend_q.push_back(tx_np_tag);
			cpl_valid <= 1'b0;
			cpl_tag <= ~cpl_tag;
			cpl_len <= ~cpl_len;
			// Each request returns two aligned 64-byte completions
			if (!hold && pend_q.size() > 0)
			begin
				cpl_valid <= 1'b1;
				cpl_tag <= pend_q[0];
				cpl_len <= 13'h0040;
				half_r <= !half_r;
				if (half_r)
					void'(pend_q.pop_front());
			end
			else if (stray)
			begin
				cpl_valid <= 1'b1;
				cpl_tag <= 5'h1F;
				cpl_len <= 13'h0004;
			end
		end
	end
endmodule

// ===== test/lim_checker.sv
`timescale 1ns/1ps
module lim_checker
	import credit_limiter_pkg::*;
(
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic np_req_valid,
	input wire logic [TAG_W-1:0] np_req_tag,
	input wire logic np_req_done,
	input wire logic tx_np_valid,
	input wire logic [TAG_W-1:0] tx_np_tag,
	input wire logic tx_np_ready,
	input wire logic cpl_ready,
	input wire logic at_ceiling
);
	default clocking @(posedge clk_sys);
	endclocking
	default disable iff (!nrst);
	a_done_after_take: assert property (tx_np_valid && tx_np_ready |=> np_req_done)
		else $error("done missing after accept");
	a_done_needs_take: assert property (np_req_done |-> $past(tx_np_valid && tx_np_ready))
		else $error("done without accept");
	a_done_one_pulse: assert property (np_req_done |=> !np_req_done && !tx_np_valid)
		else $error("done longer than one cycle");
	a_offer_holds: assert property (tx_np_valid && !tx_np_ready |=> tx_np_valid)
		else $error("offer dropped");
	a_offer_tag_stable: assert property (tx_np_valid && !tx_np_ready |=> $stable(tx_np_tag))
		else $error("offer tag changed");
	a_offer_needs_req: assert property ($rose(tx_np_valid) |-> $past(np_req_valid))
		else $error("offer without request");
	a_offer_tag_match: assert property ($rose(tx_np_valid) |-> tx_np_tag == $past(np_req_tag))
		else $error("offer tag wrong");
	a_no_take_full: assert property ($rose(tx_np_valid) |-> !at_ceiling)
		else $error("request sent at ceiling");
	a_ready_held: assert property ($past(nrst) |-> cpl_ready)
		else $error("completion ready dropped");
	c_take: cover property (tx_np_valid && tx_np_ready);
	c_full: cover property ($rose(at_ceiling));
	c_blocked: cover property (np_req_valid && at_ceiling);
endmodule
bind completion_credit_limiter lim_checker u_chk (.clk_sys(clk_sys), .nrst(nrst),
	.np_req_valid(np_req_valid), .np_req_tag(np_req_tag), .np_req_done(np_req_done),
	.tx_np_valid(tx_np_valid), .tx_np_tag(tx_np_tag), .tx_np_ready(tx_np_ready),
	.cpl_ready(cpl_ready), .at_ceiling(at_ceiling));

// ===== test/tb_top.sv
`timescale 1ns/1ps
module tb_top;
	import credit_limiter_pkg::*;
	logic clk_sys, nrst, rd, wr, wrq, nv, nd, tv, tr, cv, cr, full, slow, hold, stray;
	logic [2:0] adr;
	logic [31:0] wd, rdat, st;
	logic [15:0] dc, lc;
	logic [TAG_W-1:0] ntag, ttag, ctag;
	logic [BYTE_W-1:0] clen, nbytes;
	int n_fail, total_checks, i;
	logic [7:0] ct [7] = '{8'h01, 8'h05, 8'h3B, 8'h2B, 8'h13, 8'h03, 8'h33};
	logic [15:0] dt [7] = '{16'h5000, 16'h0000, 16'h5000, 16'h1000, 16'h2000, 16'h6000, 16'h3000};
	logic [15:0] lt [7] = '{16'h0008, 16'h0000, 16'h0008, 16'h0008, 16'h0008, 16'h0000, 16'h0000};
	logic [31:0] et [7] = '{32'h900, 32'h800, 32'h100, 32'h1200, 32'h200, 32'h40900, 32'h200};
	completion_credit_limiter DUT (.clk_sys(clk_sys), .nrst(nrst), .avs_address(adr),
		.avs_read(rd), .avs_write(wr), .avs_writedata(wd), .avs_readdata(rdat),
		.avs_waitrequest(wrq), .cfg_dcommand(dc), .cfg_lcommand(lc), .np_req_valid(nv),
		.np_req_tag(ntag), .np_req_bytes(nbytes), .np_req_done(nd), .tx_np_valid(tv),
		.tx_np_tag(ttag), .tx_np_ready(tr), .cpl_valid(cv), .cpl_tag(ctag), .cpl_len(clen),
		.cpl_ready(cr), .at_ceiling(full));
	core_model partner (.clk_sys(clk_sys), .nrst(nrst), .slow(slow), .hold(hold),
		.stray(stray), .tx_np_valid(tv), .tx_np_tag(ttag), .tx_np_ready(tr),
		.cpl_valid(cv), .cpl_tag(ctag), .cpl_len(clen));
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic close_out();
		$display("checks=%0d fails=%0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// One Avalon access; read data lands in st
	task automatic bus(input logic w, input logic [2:0] a, input logic [31:0] d);
		int k;
		@(posedge clk_sys);
		rd <= !w;
		wr <= w;
		adr <= a;
		wd <= d;
		for (k = 0; k < 50 && wrq !== 1'b0; k++)
			@(posedge clk_sys);
		if (k == 50)
		begin
			n_fail++;
			close_out();
		end
		st = rdat;
		rd <= 1'b0;
		wr <= 1'b0;
	endtask
	// Offer a request of the current nbytes size and hold it until the gate reports it sent
	task automatic req(input logic [TAG_W-1:0] t);
		int k;
		@(posedge clk_sys);
		nv <= 1'b1;
		ntag <= t;
		for (k = 0; k < 300 && nd !== 1'b1; k++)
			@(posedge clk_sys);
		if (k == 300)
		begin
			n_fail++;
			close_out();
		end
		nv <= 1'b0;
	endtask
	initial
	begin
		clk_sys = 1'b0;
		forever #10 clk_sys = ~clk_sys;
	end
	initial
	begin
		{rd, wr, nv, slow, hold, stray, adr, wd, dc, lc, ntag} = '0;
		nbytes = 13'h0080;
		n_fail = 0;
		total_checks = 0;
		nrst = 1'b0;
		repeat (5) @(posedge clk_sys);
		nrst <= 1'b1;
		repeat (2) @(posedge clk_sys);
		bus(1'b0, REG_CTRL, 32'h0);
		chk(st, 32'h01);
		bus(1'b0, REG_CAP, 32'h0);
		chk(st, 32'h0);
		bus(1'b1, 3'h7, 32'hFFFFFFFF);
		bus(1'b0, 3'h7, 32'h0);
		chk(st, 32'h0);
		chk({31'h0, cr}, 32'h1);
		for (i = 0; i < 7; i++)
		begin
			dc <= dt[i];
			lc <= lt[i];
			bus(1'b1, REG_CTRL, {24'h0, ct[i]});
			repeat (3) @(posedge clk_sys);
			bus(1'b0, REG_STATUS, 32'h0);
			chk(st, et[i]);
		end
		bus(1'b1, REG_CTRL, 32'h01);
		bus(1'b1, REG_CAP, 32'h02);
		slow <= 1'b1;
		hold <= 1'b1;
		req(5'h01);
		req(5'h02);
		bus(1'b0, REG_STATUS, 32'h0);
		chk(st & 32'h2007F, 32'h20002);
		fork
			req(5'h03);
			begin
				repeat (20) @(posedge clk_sys);
				chk({30'h0, tv, full}, 32'h1);
				hold <= 1'b0;
			end
		join
		// Request 3 waits from its first sampled edge until tag 1 has retired
		bus(1'b0, REG_STALL, 32'h0);
		chk(st, 32'h17);
		slow <= 1'b0;
		for (i = 4; i < 8; i++)
			req(i[TAG_W-1:0]);
		// A short read still takes a whole slot and retires on its first reply
		nbytes <= 13'h0004;
		req(5'h08);
		repeat (20) @(posedge clk_sys);
		bus(1'b0, REG_ISSUED, 32'h0);
		chk(st, 32'h8);
		bus(1'b0, REG_RETIRED, 32'h0);
		chk(st, 32'h8);
		bus(1'b0, REG_STATUS, 32'h0);
		chk(st & 32'h2007F, 32'h0);
		stray <= 1'b1;
		@(posedge clk_sys);
		stray <= 1'b0;
		repeat (4) @(posedge clk_sys);
		bus(1'b0, REG_ORPHAN, 32'h0);
		chk(st, 32'h2);
		bus(1'b1, REG_ORPHAN, 32'h0);
		bus(1'b0, REG_ORPHAN, 32'h0);
		chk(st, 32'h0);
		close_out();
	end
endmodule
